// ---- rtl/adcci_map.vh ----
// Constants for the converter comparator, interrupt and averaging block
`ifndef ADCCI_MAP_VH
`define ADCCI_MAP_VH

// ------------------------------------------------------------------------
// Sizes
// ------------------------------------------------------------------------
`define ADCCI_DATA_W      12
`define ADCCI_SUM_W       18
`define ADCCI_CNT_W       7
`define ADCCI_NCMP        4
`define ADCCI_NSEQ        4

// ------------------------------------------------------------------------
// Band codes
// ------------------------------------------------------------------------
`define ADCCI_BAND_LOW    2'h0
`define ADCCI_BAND_MID    2'h1
`define ADCCI_BAND_HIGH   2'h2
`define ADCCI_BAND_NONE   2'h3

// ------------------------------------------------------------------------
// Trigger and interrupt mode codes
// ------------------------------------------------------------------------
`define ADCCI_MODE_NONE       4'h0
`define ADCCI_MODE_LOW_ALW    4'h1
`define ADCCI_MODE_LOW_ONCE   4'h2
`define ADCCI_MODE_LOW_HALW   4'h3
`define ADCCI_MODE_LOW_HONCE  4'h4
`define ADCCI_MODE_MID_ALW    4'h5
`define ADCCI_MODE_MID_ONCE   4'h6
`define ADCCI_MODE_HIGH_ALW   4'h7
`define ADCCI_MODE_HIGH_ONCE  4'h8
`define ADCCI_MODE_HIGH_HALW  4'h9
`define ADCCI_MODE_HIGH_HONCE 4'hA

// ------------------------------------------------------------------------
// Averaging codes: factor is two to the power of the code
// ------------------------------------------------------------------------
`define ADCCI_AVG_OFF     3'h0
`define ADCCI_AVG_MAX     3'h6

// ------------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------------
`define ADCCI_RST_4       4'h0
`define ADCCI_RST_DATA    12'h000
`define ADCCI_RST_SUM     18'h00000
`define ADCCI_RST_CNT     7'h00

`endif

// ---- rtl/adcci_top.v ----
// Comparator bands, comparator and sequence interrupts, hardware averaging
`timescale 1ns/1ps
`default_nettype none
`include "adcci_map.vh"

// Function
// - Result at or below low threshold: low
// - Above low, not above high: mid
// - Strictly above high threshold: high
// - Trigger, interrupt modes selected independently per comparator
// - Software resets trigger, interrupt state separately
// - One comparator status word, sequence agnostic
// - Mask write clears exactly selected status bits
// - Comparator interrupt enabled per sample sequence
// - Averaging by 2, 4, 8, 16, 32, 64
// - Factor zero stores each conversion directly
// - Averaging uniform; one averaged entry per write
// - Throughput drops by the averaging factor
// - Clearing sequence status drops its request
// - Per sequence interrupt enable, clearable
// - Enabling sequence interrupt first clears pending status
// - Raw status and masked status per sequence
module adcci_top (
    input  wire        sys_clk,
    input  wire        srst,
    input  wire        conv_valid,
    input  wire [11:0] conv_data,
    input  wire [1:0]  conv_seq,
    input  wire        conv_cmp_en,
    input  wire [1:0]  conv_cmp_idx,
    input  wire [2:0]  averaging_factor,
    input  wire [47:0] low_band_threshold,
    input  wire [47:0] high_band_threshold,
    input  wire [15:0] comparator_trigger_mode,
    input  wire [15:0] comparator_int_mode,
    input  wire [3:0]  reset_trigger_state,
    input  wire [3:0]  reset_int_state,
    input  wire        cmp_status_clr_wr,
    input  wire [3:0]  cmp_status_clr_mask,
    input  wire [3:0]  cmp_int_enable_set,
    input  wire [3:0]  cmp_int_disable,
    input  wire [3:0]  seq_done,
    input  wire [3:0]  seq_int_clr,
    input  wire [3:0]  seq_int_enable_set,
    input  wire [3:0]  seq_int_disable,
    input  wire        masked_status_select,
    input  wire [1:0]  status_seq_sel,
    output reg         fifo_wr_valid_ff,
    output reg  [11:0] fifo_wr_data_ff,
    output reg  [1:0]  fifo_wr_seq_ff,
    output reg  [3:0]  cmp_trig_ff,
    output reg  [3:0]  cmp_status_ff,
    output reg         cmp_irq_ff,
    output reg  [3:0]  cmp_int_en_ff,
    output reg  [3:0]  seq_int_en_ff,
    output reg  [3:0]  seq_raw_ff,
    output reg  [3:0]  seq_masked_ff,
    output reg  [3:0]  seq_irq_ff,
    output reg         seq_status_ff
);

    // --------------------------------------------------------------------
    // Mode decision helpers
    // --------------------------------------------------------------------
    function fire_fn;
        input [3:0] mode;
        input [1:0] band;
        input [1:0] prev;
        input       arm;
        reg         is_lo;
        reg         is_mi;
        reg         is_hi;
        begin
            is_lo = (band == `ADCCI_BAND_LOW);
            is_mi = (band == `ADCCI_BAND_MID);
            is_hi = (band == `ADCCI_BAND_HIGH);
            case (mode)
                `ADCCI_MODE_LOW_ALW:    fire_fn = is_lo;
                `ADCCI_MODE_LOW_ONCE:   fire_fn = is_lo && (prev != band);
                `ADCCI_MODE_LOW_HALW:   fire_fn = is_lo && arm;
                `ADCCI_MODE_LOW_HONCE:
                    fire_fn = is_lo && arm && (prev != band);
                `ADCCI_MODE_MID_ALW:    fire_fn = is_mi;
                `ADCCI_MODE_MID_ONCE:   fire_fn = is_mi && (prev != band);
                `ADCCI_MODE_HIGH_ALW:   fire_fn = is_hi;
                `ADCCI_MODE_HIGH_ONCE:  fire_fn = is_hi && (prev != band);
                `ADCCI_MODE_HIGH_HALW:  fire_fn = is_hi && arm;
                `ADCCI_MODE_HIGH_HONCE:
                    fire_fn = is_hi && arm && (prev != band);
                default:                fire_fn = 1'b0;
            endcase
        end
    endfunction

    // Hysteresis arm: set by the opposite band, spent by an output
    function arm_fn;
        input [3:0] mode;
        input [1:0] band;
        input       arm;
        input       fired;
        reg         lo_h;
        reg         hi_h;
        begin
            lo_h = (mode == `ADCCI_MODE_LOW_HALW) ||
                   (mode == `ADCCI_MODE_LOW_HONCE);
            hi_h = (mode == `ADCCI_MODE_HIGH_HALW) ||
                   (mode == `ADCCI_MODE_HIGH_HONCE);
            if (fired) begin
                arm_fn = 1'b0;
            end else if (lo_h && band == `ADCCI_BAND_HIGH) begin
                arm_fn = 1'b1;
            end else if (hi_h && band == `ADCCI_BAND_LOW) begin
                arm_fn = 1'b1;
            end else begin
                arm_fn = arm;
            end
        end
    endfunction

    // --------------------------------------------------------------------
    // Hardware averaging
    // --------------------------------------------------------------------
    reg  [17:0] acc_sum_ff;
    reg  [6:0]  acc_cnt_ff;
    reg  [1:0]  acc_seq_ff;
    reg  [2:0]  acc_code_ff;
    reg         out_cmp_en_ff;
    reg  [1:0]  out_cmp_idx_ff;
    wire [2:0]  code_eff;
    wire        fresh;
    wire [17:0] nxt_sum;
    wire [6:0]  nxt_cnt;
    wire [6:0]  need_cnt;
    wire        emit;
    wire [17:0] avg_full;

    // Out of range codes behave as off
    assign code_eff = (averaging_factor > `ADCCI_AVG_MAX) ?
                      `ADCCI_AVG_OFF : averaging_factor;
    // Factor or sequence change restarts; stale partial sums never mix
    assign fresh    = (acc_cnt_ff == `ADCCI_RST_CNT) ||
                      (conv_seq != acc_seq_ff) || (code_eff != acc_code_ff);
    assign nxt_sum  = (fresh ? `ADCCI_RST_SUM : acc_sum_ff) +
                      {6'h00, conv_data};
    assign nxt_cnt  = fresh ? 7'h01 : (acc_cnt_ff + 7'h01);
    // Factor is two to the code
    assign need_cnt = 7'h01 << code_eff;
    assign emit     = conv_valid && (nxt_cnt == need_cnt);
    assign avg_full = nxt_sum >> code_eff;

    always @(posedge sys_clk) begin
        if (srst) begin
            acc_sum_ff       <= `ADCCI_RST_SUM;
            acc_cnt_ff       <= `ADCCI_RST_CNT;
            acc_seq_ff       <= 2'h0;
            acc_code_ff      <= `ADCCI_AVG_OFF;
            fifo_wr_valid_ff <= 1'b0;
            fifo_wr_data_ff  <= `ADCCI_RST_DATA;
            fifo_wr_seq_ff   <= 2'h0;
            out_cmp_en_ff    <= 1'b0;
            out_cmp_idx_ff   <= 2'h0;
        end else begin
            fifo_wr_valid_ff <= emit;
            if (conv_valid) begin
                acc_sum_ff  <= nxt_sum;
                acc_seq_ff  <= conv_seq;
                acc_code_ff <= code_eff;
                acc_cnt_ff  <= emit ? `ADCCI_RST_CNT : nxt_cnt;
            end
            // Only fully averaged results are written
            if (emit) begin
                fifo_wr_data_ff <= avg_full[11:0];
                fifo_wr_seq_ff  <= conv_seq;
                out_cmp_en_ff   <= conv_cmp_en;
                out_cmp_idx_ff  <= conv_cmp_idx;
            end
        end
    end

    // --------------------------------------------------------------------
    // Digital comparators
    // --------------------------------------------------------------------
    wire [3:0] trig_hit;
    wire [3:0] int_hit;

    genvar g;
    generate
        for (g = 0; g < `ADCCI_NCMP; g = g + 1) begin : gen_cmp
            reg  [1:0]  trig_prev_ff;
            reg         trig_arm_ff;
            reg  [1:0]  int_prev_ff;
            reg         int_arm_ff;
            reg  [1:0]  band;
            wire [11:0] lo_thr;
            wire [11:0] hi_thr;
            wire [3:0]  t_mode;
            wire [3:0]  i_mode;
            wire        eval;
            wire        t_fire;
            wire        i_fire;

            assign lo_thr = low_band_threshold[g*12 +: 12];
            assign hi_thr = high_band_threshold[g*12 +: 12];
            assign t_mode = comparator_trigger_mode[g*4 +: 4];
            assign i_mode = comparator_int_mode[g*4 +: 4];
            assign eval   = fifo_wr_valid_ff && out_cmp_en_ff &&
                            (out_cmp_idx_ff == g);

            always @* begin
                if (fifo_wr_data_ff <= lo_thr) begin
                    band = `ADCCI_BAND_LOW;
                end else if (fifo_wr_data_ff <= hi_thr) begin
                    band = `ADCCI_BAND_MID;
                end else begin
                    band = `ADCCI_BAND_HIGH;
                end
            end

            assign t_fire = eval &&
                            fire_fn(t_mode, band, trig_prev_ff, trig_arm_ff);
            assign i_fire = eval &&
                            fire_fn(i_mode, band, int_prev_ff, int_arm_ff);
            assign trig_hit[g] = t_fire;
            assign int_hit[g]  = i_fire;

            always @(posedge sys_clk) begin
                if (srst || reset_trigger_state[g]) begin
                    trig_prev_ff <= `ADCCI_BAND_NONE;
                    trig_arm_ff  <= 1'b0;
                end else if (eval) begin
                    trig_prev_ff <= band;
                    trig_arm_ff  <= arm_fn(t_mode, band, trig_arm_ff, t_fire);
                end
                if (srst || reset_int_state[g]) begin
                    int_prev_ff <= `ADCCI_BAND_NONE;
                    int_arm_ff  <= 1'b0;
                end else if (eval) begin
                    int_prev_ff <= band;
                    int_arm_ff  <= arm_fn(i_mode, band, int_arm_ff, i_fire);
                end
            end
        end
    endgenerate

    // --------------------------------------------------------------------
    // Comparator status and enables
    // --------------------------------------------------------------------
    wire [3:0] cmp_set;
    wire [3:0] nxt_cmp_status;

    // Only sequences with comparator interrupt enabled set status
    assign cmp_set = int_hit & {4{cmp_int_en_ff[fifo_wr_seq_ff]}};
    // Masked clear; a new event in the same cycle wins
    assign nxt_cmp_status = (cmp_status_ff &
                            ~({4{cmp_status_clr_wr}} & cmp_status_clr_mask))
                            | cmp_set;

    always @(posedge sys_clk) begin
        if (srst) begin
            cmp_trig_ff   <= `ADCCI_RST_4;
            cmp_status_ff <= `ADCCI_RST_4;
            cmp_irq_ff    <= 1'b0;
            cmp_int_en_ff <= `ADCCI_RST_4;
        end else begin
            // Trigger outputs as one cycle pulses
            cmp_trig_ff   <= trig_hit;
            cmp_status_ff <= nxt_cmp_status;
            cmp_irq_ff    <= |nxt_cmp_status;
            cmp_int_en_ff <= (cmp_int_en_ff & ~cmp_int_disable) |
                             cmp_int_enable_set;
        end
    end

    // --------------------------------------------------------------------
    // Sample sequence interrupts
    // --------------------------------------------------------------------
    wire [3:0] nxt_seq_en;
    wire [3:0] nxt_seq_raw;
    wire [3:0] nxt_seq_masked;

    // Enable set and clear per sequence
    assign nxt_seq_en     = (seq_int_en_ff & ~seq_int_disable) |
                            seq_int_enable_set;
    // Clear or enable drops pending; done still wins
    assign nxt_seq_raw    = (seq_raw_ff &
                            ~(seq_int_clr | seq_int_enable_set)) | seq_done;
    // Masked is raw gated by enable
    assign nxt_seq_masked = nxt_seq_raw & nxt_seq_en;

    always @(posedge sys_clk) begin
        if (srst) begin
            seq_int_en_ff <= `ADCCI_RST_4;
            seq_raw_ff    <= `ADCCI_RST_4;
            seq_masked_ff <= `ADCCI_RST_4;
            seq_irq_ff    <= `ADCCI_RST_4;
            seq_status_ff <= 1'b0;
        end else begin
            seq_int_en_ff <= nxt_seq_en;
            seq_raw_ff    <= nxt_seq_raw;
            seq_masked_ff <= nxt_seq_masked;
            seq_irq_ff    <= nxt_seq_masked;
            if (masked_status_select) begin
                seq_status_ff <= nxt_seq_masked[status_seq_sel];
            end else begin
                seq_status_ff <= nxt_seq_raw[status_seq_sel];
            end
        end
    end

endmodule
`default_nettype wire

// ---- testbench/adcci_top_asserts.sv ----
// Checker for the comparator, interrupt and averaging block
`timescale 1ns/1ps
`default_nettype none
module adcci_top_asserts (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        conv_valid,
    input wire logic [11:0] conv_data,
    input wire logic [2:0]  averaging_factor,
    input wire logic        cmp_status_clr_wr,
    input wire logic [3:0]  cmp_status_clr_mask,
    input wire logic [3:0]  seq_done,
    input wire logic [3:0]  seq_int_clr,
    input wire logic [3:0]  seq_int_enable_set,
    input wire logic [3:0]  seq_int_disable,
    input wire logic        fifo_wr_valid_ff,
    input wire logic [11:0] fifo_wr_data_ff,
    input wire logic [3:0]  cmp_trig_ff,
    input wire logic [3:0]  cmp_status_ff,
    input wire logic [3:0]  seq_int_en_ff,
    input wire logic [3:0]  seq_raw_ff,
    input wire logic [3:0]  seq_masked_ff,
    input wire logic [3:0]  seq_irq_ff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    property p_avg_off;
        conv_valid && averaging_factor == 3'h0
        |=> fifo_wr_valid_ff && fifo_wr_data_ff == $past(conv_data);
    endproperty
    a_avg_off: assert property (p_avg_off) else $error("direct");
    property p_trig_src;
        cmp_trig_ff != 4'h0 |-> $past(fifo_wr_valid_ff);
    endproperty
    a_trig_src: assert property (p_trig_src) else $error("trigger");
    property p_raw_set;
        seq_done != 4'h0 |=> (seq_raw_ff & $past(seq_done)) == $past(seq_done);
    endproperty
    a_raw_set: assert property (p_raw_set) else $error("raw set");
    property p_clr;
        seq_int_clr[0] && !seq_done[0] |=> !seq_raw_ff[0] ##0 !seq_irq_ff[0];
    endproperty
    a_clr: assert property (p_clr) else $error("seq clear");
    property p_en_clr;
        seq_int_enable_set[1] && !seq_done[1]
        |=> seq_int_en_ff[1] && !seq_raw_ff[1];
    endproperty
    a_en_clr: assert property (p_en_clr) else $error("enable");
    property p_dis;
        seq_int_disable[2] && !seq_int_enable_set[2]
        |=> !seq_int_en_ff[2] && !seq_irq_ff[2];
    endproperty
    a_dis: assert property (p_dis) else $error("disable");
    property p_masked;
        seq_masked_ff == (seq_raw_ff & seq_int_en_ff);
    endproperty
    a_masked: assert property (p_masked) else $error("masked");
    property p_irq;
        seq_irq_ff == seq_masked_ff;
    endproperty
    a_irq: assert property (p_irq) else $error("seq request");
    property p_cmp_clr;
        cmp_status_clr_wr && !fifo_wr_valid_ff
        |=> cmp_status_ff ==
            ($past(cmp_status_ff) & ~$past(cmp_status_clr_mask));
    endproperty
    a_cmp_clr: assert property (p_cmp_clr) else $error("mask clear");
    c_irq: cover property (seq_irq_ff != 4'h0);
    c_trig: cover property (cmp_trig_ff != 4'h0);
    c_avg: cover property (fifo_wr_valid_ff && averaging_factor == 3'h6);
endmodule
bind adcci_top adcci_top_asserts u_chk (.sys_clk(sys_clk), .srst(srst),
    .conv_valid(conv_valid), .conv_data(conv_data),
    .averaging_factor(averaging_factor), .cmp_status_clr_wr(cmp_status_clr_wr),
    .cmp_status_clr_mask(cmp_status_clr_mask), .seq_done(seq_done),
    .seq_int_clr(seq_int_clr), .seq_int_enable_set(seq_int_enable_set),
    .seq_int_disable(seq_int_disable), .fifo_wr_valid_ff(fifo_wr_valid_ff),
    .fifo_wr_data_ff(fifo_wr_data_ff), .cmp_trig_ff(cmp_trig_ff),
    .cmp_status_ff(cmp_status_ff), .seq_int_en_ff(seq_int_en_ff),
    .seq_raw_ff(seq_raw_ff), .seq_masked_ff(seq_masked_ff),
    .seq_irq_ff(seq_irq_ff));
`default_nettype wire

// ---- testbench/adcci_top_tb.sv ----
// Self-checking bench for the comparator, interrupt and averaging block
`timescale 1ns/1ps
`default_nettype none
`include "adcci_map.vh"
module adcci_top_tb;
    logic        sys_clk, srst, conv_valid, conv_cmp_en, cmp_status_clr_wr;
    logic        masked_status_select;
    logic [11:0] conv_data, lo, hi, d;
    logic [1:0]  conv_seq, conv_cmp_idx, status_seq_sel;
    logic [2:0]  averaging_factor;
    logic [47:0] low_band_threshold, high_band_threshold;
    logic [15:0] comparator_trigger_mode, comparator_int_mode;
    logic [3:0]  reset_trigger_state, reset_int_state, cmp_status_clr_mask;
    logic [3:0]  cmp_int_enable_set, cmp_int_disable, seq_done, seq_int_clr;
    logic [3:0]  seq_int_enable_set, seq_int_disable, am;
    logic [17:0] sum;
    wire         fifo_wr_valid_ff, cmp_irq_ff, seq_status_ff;
    wire  [11:0] fifo_wr_data_ff;
    wire  [1:0]  fifo_wr_seq_ff;
    wire  [3:0]  cmp_trig_ff, cmp_status_ff, cmp_int_en_ff, seq_int_en_ff;
    wire  [3:0]  seq_raw_ff, seq_masked_ff, seq_irq_ff;
    integer      failures, n_tests, seed, c, k, n, s, g;
    adcci_top dut (.sys_clk(sys_clk), .srst(srst), .conv_valid(conv_valid),
        .conv_data(conv_data), .conv_seq(conv_seq), .conv_cmp_en(conv_cmp_en),
        .conv_cmp_idx(conv_cmp_idx), .averaging_factor(averaging_factor),
        .low_band_threshold(low_band_threshold),
        .high_band_threshold(high_band_threshold),
        .comparator_trigger_mode(comparator_trigger_mode),
        .comparator_int_mode(comparator_int_mode),
        .reset_trigger_state(reset_trigger_state),
        .reset_int_state(reset_int_state),
        .cmp_status_clr_wr(cmp_status_clr_wr),
        .cmp_status_clr_mask(cmp_status_clr_mask),
        .cmp_int_enable_set(cmp_int_enable_set),
        .cmp_int_disable(cmp_int_disable), .seq_done(seq_done),
        .seq_int_clr(seq_int_clr), .seq_int_enable_set(seq_int_enable_set),
        .seq_int_disable(seq_int_disable),
        .masked_status_select(masked_status_select),
        .status_seq_sel(status_seq_sel), .fifo_wr_valid_ff(fifo_wr_valid_ff),
        .fifo_wr_data_ff(fifo_wr_data_ff), .fifo_wr_seq_ff(fifo_wr_seq_ff),
        .cmp_trig_ff(cmp_trig_ff), .cmp_status_ff(cmp_status_ff),
        .cmp_irq_ff(cmp_irq_ff), .cmp_int_en_ff(cmp_int_en_ff),
        .seq_int_en_ff(seq_int_en_ff), .seq_raw_ff(seq_raw_ff),
        .seq_masked_ff(seq_masked_ff), .seq_irq_ff(seq_irq_ff),
        .seq_status_ff(seq_status_ff));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Run is under a thousand cycles; generous margin
    initial begin
        #100000;
        failures = failures + 1;
        give_verdict;
    end
    task step;
        begin
            @(posedge sys_clk);
            #1;
        end
    endtask
    task chk(input string nm, input [11:0] e, input [11:0] v);
        begin
            n_tests = n_tests + 1;
            if (v !== e) begin
                failures = failures + 1;
                $display("ERROR %0s expected %h seen %h", nm, e, v);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("Checks %0d mismatches %0d", n_tests, failures);
            if (failures == 0 && n_tests > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    function [1:0] band(input [11:0] v);
        band = (v <= lo) ? `ADCCI_BAND_LOW :
               (v <= hi) ? `ADCCI_BAND_MID : `ADCCI_BAND_HIGH;
    endfunction
    task sample(input [11:0] v, input en);
        begin
            conv_valid = 1'b1;
            conv_data = v;
            conv_cmp_en = en;
            step;
        end
    endtask
    // Held a cycle, released a cycle: no double drive at one edge
    task pulse(input [2:0] w, input [3:0] v);
        begin
            case (w)
                3'h0: seq_done = v;
                3'h1: seq_int_clr = v;
                3'h2: seq_int_enable_set = v;
                3'h3: seq_int_disable = v;
                3'h4: cmp_int_enable_set = v;
                3'h5: cmp_int_disable = v;
                3'h6: reset_trigger_state = v;
                default: reset_int_state = v;
            endcase
            step;
            {seq_done, seq_int_clr, seq_int_enable_set, seq_int_disable,
             cmp_int_enable_set, cmp_int_disable, reset_trigger_state,
             reset_int_state} = 32'h0;
            step;
        end
    endtask
    task eval(input [3:0] m, input [11:0] v, input et, input ei);
        begin
            comparator_trigger_mode[g*4+:4] = m;
            comparator_int_mode[g*4+:4] = m;
            sample(v, 1'b1);
            conv_valid = 1'b0;
            step;
            chk("trigger", et, cmp_trig_ff[g]);
            chk("status", ei, cmp_status_ff[g]);
            chk("irq", ei, cmp_irq_ff);
            cmp_status_clr_wr = 1'b1;
            cmp_status_clr_mask = ~(4'h1 << g);
            step;
            chk("kept", ei, cmp_status_ff[g]);
            cmp_status_clr_mask = 4'hF;
            step;
            cmp_status_clr_wr = 1'b0;
            chk("cleared", 12'h0, {cmp_irq_ff, cmp_status_ff});
        end
    endtask
    task rst2;
        begin
            pulse(3'h6, 4'h1 << g);
            pulse(3'h7, 4'h1 << g);
        end
    endtask
    initial begin
        seed = 32'h131b;
        failures = 0;
        n_tests = 0;
        {conv_valid, conv_cmp_en, cmp_status_clr_wr, masked_status_select,
         conv_data, conv_seq, conv_cmp_idx, status_seq_sel, averaging_factor,
         low_band_threshold, high_band_threshold, comparator_trigger_mode,
         comparator_int_mode, cmp_status_clr_mask} = 0;
        {seq_done, seq_int_clr, seq_int_enable_set, seq_int_disable,
         cmp_int_enable_set, cmp_int_disable, reset_trigger_state,
         reset_int_state} = 32'h0;
        srst = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
        chk("reset", 12'h0, {cmp_trig_ff, cmp_status_ff, seq_raw_ff});
        srst = 1'b0;
        // Code 7 reads as off
        for (c = 0; c < 8; c = c + 1) begin
            averaging_factor = c;
            k = (c == 7) ? 0 : c;
            sum = 18'h0;
            conv_seq = $random(seed);
            for (n = 0; n < (1 << k); n = n + 1) begin
                d = $random(seed);
                sum = sum + d;
                sample(d, 1'b0);
                if (n < (1 << k) - 1)
                    chk("early", 12'h0, fifo_wr_valid_ff);
            end
            conv_valid = 1'b0;
            chk("valid", 12'h1, fifo_wr_valid_ff);
            chk("average", sum >> k, fifo_wr_data_ff);
            chk("seq", conv_seq, fifo_wr_seq_ff);
            step;
        end
        $display("Averaging test done");
        averaging_factor = 3'h0;
        g = $random(seed) & 3;
        s = $random(seed) & 3;
        conv_cmp_idx = g;
        conv_seq = s;
        lo = 12'h100 + ($random(seed) & 12'h3FF);
        hi = lo + 12'h200 + ($random(seed) & 12'h3FF);
        low_band_threshold[g*12+:12] = lo;
        high_band_threshold[g*12+:12] = hi;
        pulse(3'h4, 4'h1 << s);
        chk("cmp enable", 4'h1 << s, cmp_int_en_ff);
        for (k = 0; k < 18; k = k + 1) begin
            d = (k == 0) ? lo : (k == 1) ? lo + 1 : (k == 2) ? hi :
                (k == 3) ? hi + 1 : (k == 4) ? 12'h000 : (k == 5) ? 12'hFFF :
                $random(seed);
            for (n = 0; n < 3; n = n + 1) begin
                am = (n == 0) ? `ADCCI_MODE_LOW_ALW : (n == 1) ?
                     `ADCCI_MODE_MID_ALW : `ADCCI_MODE_HIGH_ALW;
                eval(am, d, band(d) == n, band(d) == n);
            end
        end
        rst2;
        eval(`ADCCI_MODE_MID_ONCE, lo + 1, 1'b1, 1'b1);
        eval(`ADCCI_MODE_MID_ONCE, lo + 1, 1'b0, 1'b0);
        eval(`ADCCI_MODE_MID_ONCE, lo, 1'b0, 1'b0);
        eval(`ADCCI_MODE_MID_ONCE, lo + 1, 1'b1, 1'b1);
        pulse(3'h6, 4'h1 << g);
        eval(`ADCCI_MODE_MID_ONCE, lo + 1, 1'b1, 1'b0);
        eval(`ADCCI_MODE_LOW_ONCE, lo, 1'b1, 1'b1);
        eval(`ADCCI_MODE_HIGH_ONCE, hi + 1, 1'b1, 1'b1);
        eval(`ADCCI_MODE_HIGH_ONCE, hi + 1, 1'b0, 1'b0);
        rst2;
        eval(`ADCCI_MODE_HIGH_HALW, hi + 1, 1'b0, 1'b0);
        eval(`ADCCI_MODE_HIGH_HALW, lo, 1'b0, 1'b0);
        eval(`ADCCI_MODE_HIGH_HALW, hi + 1, 1'b1, 1'b1);
        eval(`ADCCI_MODE_HIGH_HALW, hi + 1, 1'b0, 1'b0);
        rst2;
        eval(`ADCCI_MODE_LOW_HALW, lo, 1'b0, 1'b0);
        eval(`ADCCI_MODE_LOW_HALW, hi + 1, 1'b0, 1'b0);
        eval(`ADCCI_MODE_LOW_HALW, lo, 1'b1, 1'b1);
        rst2;
        eval(`ADCCI_MODE_LOW_HONCE, hi + 1, 1'b0, 1'b0);
        eval(`ADCCI_MODE_LOW_HONCE, lo, 1'b1, 1'b1);
        // Output spent the arm; low band re-arms the high side
        eval(`ADCCI_MODE_HIGH_HONCE, lo, 1'b0, 1'b0);
        eval(`ADCCI_MODE_HIGH_HONCE, hi + 1, 1'b1, 1'b1);
        eval(`ADCCI_MODE_NONE, lo, 1'b0, 1'b0);
        pulse(3'h5, 4'h1 << s);
        chk("cmp disable", 12'h0, cmp_int_en_ff);
        eval(`ADCCI_MODE_MID_ALW, lo + 1, 1'b1, 1'b0);
        $display("Comparator test done");
        for (s = 0; s < 4; s = s + 1) begin
            status_seq_sel = s;
            pulse(3'h0, 4'h1 << s);
            chk("raw", 12'h1, seq_raw_ff[s]);
            chk("raw readback", 12'h1, seq_status_ff);
            pulse(3'h2, 4'h1 << s);
            chk("enable", 4'h1 << s, seq_int_en_ff);
            chk("stale", 12'h0, seq_raw_ff[s]);
            pulse(3'h0, 4'h1 << s);
            chk("request", 12'h1, seq_irq_ff[s]);
            masked_status_select = 1'b1;
            step;
            chk("masked readback", 12'h1, seq_status_ff);
            masked_status_select = 1'b0;
            pulse(3'h1, 4'h1 << s);
            chk("cleared", 12'h0, seq_irq_ff[s]);
            pulse(3'h0, 4'h1 << s);
            pulse(3'h3, 4'h1 << s);
            chk("masked", 12'h0, seq_masked_ff[s]);
            chk("raw kept", 12'h1, seq_raw_ff[s]);
            pulse(3'h1, 4'h1 << s);
        end
        $display("Sequence interrupt test done");
        give_verdict;
    end
endmodule
`default_nettype wire
